// [vxe_exit_encoder.sv]
// Guest exit reason encoder: takes one exit event, stores its code in the
// guest control block and only then lets host execution resume.
// Assumes the core offers exit events synchronous to i_clk and a memory
// port that accepts the control block store with a ready handshake.
//
// Contract
// - Every guest exit stores a cause code.
// - Low codes match intercept vector bit positions.
// - Control register n read gives 00h plus n.
// - Control register n write gives 10h plus n.
// - Debug register n read gives 20h plus n.
// - Debug register n write gives 30h plus n.
// - Exception vector v gives 40h plus v.
// - Physical maskable interrupt gives code 60h.
// - System management interrupt gives 62h plus detail.
// - Processor initialisation signal gives code 63h.
// - Pending virtual interrupt gives code 64h.
// - Selective zero write exits only on others.
// - Table register reads give 66h to 69h.
// - Flags push 70h, flags pop 71h.
// - System management return gives code 73h.
// - Software interrupt instruction gives code 75h.
// - Non-maskable interrupt gives code 61h.
`timescale 1ns/10ps
`default_nettype none
module vxe_exit_encoder
    import vxe_pkg::*;
#(
    parameter int VEC_W = VXE_VEC_W
)(
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_en,
    input  wire logic             i_exit_valid,
    input  wire vxe_exit_req_t    i_exit_req,
    input  wire logic [VEC_W-1:0] i_intercept_vec,
    input  wire logic             i_cb_wr_ready,
    output logic                  o_exit_ready,
    output logic                  o_cb_wr_valid,
    output vxe_cb_wr_t            o_cb,
    output logic                  o_resume_host,
    output logic                  o_no_exit,
    output logic                  o_cause_error
);

    // -------------------------------------------------------------------------
    // Cause decoding
    // -------------------------------------------------------------------------
    vxe_state_t  state;
    vxe_state_t  next_state;
    vxe_cb_wr_t  next_cb;
    logic        next_no_exit;
    logic        next_cause_error;
    logic [7:0]  map_code;
    logic        map_ok;
    logic        sel_change;
    logic        vec_hit;
    logic        take;
    logic        exit_ok;
    logic        is_sel;
    logic        is_smi;
    logic        stored;

    vxe_code_map u_code_map (
        .i_cause (i_exit_req.cause),
        .i_idx   (i_exit_req.idx),
        .o_code  (map_code),
        .o_ok    (map_ok)
    );

    vxe_ctl0_filter u_ctl0_filter (
        .i_old          (i_exit_req.old_ctl0),
        .i_new          (i_exit_req.new_ctl0),
        .o_other_change (sel_change)
    );

    // An exit is only real when the matching intercept enable is set
    assign vec_hit = (map_code <= VXE_CODE_TOP) ? i_intercept_vec[map_code] : 1'b0;
    assign is_sel  = (i_exit_req.cause == VXE_SEL0);
    assign is_smi  = (i_exit_req.cause == VXE_SMI);
    assign take    = i_en && i_exit_valid && (state == VXE_ST_IDLE);
    // Selective write touching only the ignored bits lets the guest run on
    assign exit_ok = map_ok && vec_hit && (!is_sel || sel_change);

    // -------------------------------------------------------------------------
    // Handshake outputs
    // -------------------------------------------------------------------------
    // Gated by the enable so that no handshake completes while state is frozen
    assign o_exit_ready  = i_en && (state == VXE_ST_IDLE);
    assign o_cb_wr_valid = i_en && (state == VXE_ST_STORE);
    assign o_resume_host = i_en && (state == VXE_ST_RESUME);
    assign stored        = o_cb_wr_valid && i_cb_wr_ready;

    // -------------------------------------------------------------------------
    // Next values
    // -------------------------------------------------------------------------
    assign next_cb.code      = (take && exit_ok) ? {56'h0, map_code} : o_cb.code;
    // Detail holds with the code, so the whole store group stands until it is accepted
    assign next_cb.detail    = (take && exit_ok) ? (is_smi ? i_exit_req.detail : 64'h0) : o_cb.detail;
    assign next_cb.detail_we = (take && exit_ok) ? is_smi : o_cb.detail_we;
    assign next_no_exit      = take && map_ok && !exit_ok;
    assign next_cause_error  = take && !map_ok;

    always_comb
    begin
        next_state = state;
        case (state)
            VXE_ST_IDLE:
            begin
                if (take && exit_ok)
                begin
                    next_state = VXE_ST_STORE;
                end
            end
            VXE_ST_STORE:
            begin
                // Resume waits for the store to be accepted
                if (stored)
                begin
                    next_state = VXE_ST_RESUME;
                end
            end
            VXE_ST_RESUME:
            begin
                next_state = VXE_ST_IDLE;
            end
            default:
            begin
                next_state = VXE_ST_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state         <= VXE_ST_IDLE;
            o_cb          <= '0;
            o_no_exit     <= 1'b0;
            o_cause_error <= 1'b0;
        end
        else if (i_en)
        begin
            state         <= next_state;
            o_cb          <= next_cb;
            o_no_exit     <= next_no_exit;
            o_cause_error <= next_cause_error;
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb_main @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    property p_exit_stores;
        take && exit_ok |=> state == VXE_ST_STORE && o_cb.code == {56'h0, $past(map_code)};
    endproperty
    a_exit_stores: assert property (p_exit_stores)
        else $error("exit taken but no store started");

    property p_vec_gate;
        take && map_ok && !vec_hit |=> state == VXE_ST_IDLE && o_no_exit;
    endproperty
    a_vec_gate: assert property (p_vec_gate)
        else $error("exit stored without its intercept enable");

    property p_ctl_rd;
        take && exit_ok && i_exit_req.cause == VXE_CTL_RD
            |=> o_cb.code == {60'h0, $past(i_exit_req.idx[3:0])};
    endproperty
    a_ctl_rd: assert property (p_ctl_rd)
        else $error("wrong control register read code");

    property p_ctl_wr;
        take && exit_ok && i_exit_req.cause == VXE_CTL_WR
            |=> o_cb.code == {56'h0, 4'h1, $past(i_exit_req.idx[3:0])};
    endproperty
    a_ctl_wr: assert property (p_ctl_wr)
        else $error("wrong control register write code");

    property p_dbg_rd;
        take && exit_ok && i_exit_req.cause == VXE_DBG_RD
            |=> o_cb.code == {56'h0, 4'h2, $past(i_exit_req.idx[3:0])};
    endproperty
    a_dbg_rd: assert property (p_dbg_rd)
        else $error("wrong debug register read code");

    property p_dbg_wr;
        take && exit_ok && i_exit_req.cause == VXE_DBG_WR
            |=> o_cb.code == {56'h0, 4'h3, $past(i_exit_req.idx[3:0])};
    endproperty
    a_dbg_wr: assert property (p_dbg_wr)
        else $error("wrong debug register write code");

    property p_excp;
        take && exit_ok && i_exit_req.cause == VXE_EXCP
            |=> o_cb.code == {56'h0, 3'h2, $past(i_exit_req.idx)};
    endproperty
    a_excp: assert property (p_excp)
        else $error("wrong exception vector code");

    property p_intr;
        take && exit_ok && i_exit_req.cause == VXE_INTR |=> o_cb.code == 64'h60;
    endproperty
    a_intr: assert property (p_intr)
        else $error("wrong maskable interrupt code");

    property p_smi;
        take && exit_ok && is_smi
            |=> o_cb.code == 64'h62 && o_cb.detail_we && o_cb.detail == $past(i_exit_req.detail);
    endproperty
    a_smi: assert property (p_smi)
        else $error("wrong system management interrupt code or detail");

    property p_init;
        take && exit_ok && i_exit_req.cause == VXE_INIT |=> o_cb.code == 64'h63;
    endproperty
    a_init: assert property (p_init)
        else $error("wrong initialisation code");

    property p_vintr;
        take && exit_ok && i_exit_req.cause == VXE_VINTR |=> o_cb.code == 64'h64;
    endproperty
    a_vintr: assert property (p_vintr)
        else $error("wrong virtual interrupt code");

    property p_sel0;
        take && is_sel && vec_hit
            |=> $past(sel_change) ? (o_cb.code == 64'h65 && state == VXE_ST_STORE)
                                  : (o_no_exit && state == VXE_ST_IDLE);
    endproperty
    a_sel0: assert property (p_sel0)
        else $error("selective control write handled wrongly");

    property p_tables;
        take && exit_ok && i_exit_req.cause inside {VXE_IDTR, VXE_GDTR, VXE_LDTR, VXE_TR}
            |=> o_cb.code == 64'h66 + {61'h0, 3'($past(i_exit_req.cause) - VXE_IDTR)};
    endproperty
    a_tables: assert property (p_tables)
        else $error("wrong table register read code");

    property p_flags;
        take && exit_ok && i_exit_req.cause inside {VXE_PUSHF, VXE_POPF}
            |=> o_cb.code == ($past(i_exit_req.cause) == VXE_PUSHF ? 64'h70 : 64'h71);
    endproperty
    a_flags: assert property (p_flags)
        else $error("wrong flags push or pop code");

    property p_rsm;
        take && exit_ok && i_exit_req.cause == VXE_RSM |=> o_cb.code == 64'h73;
    endproperty
    a_rsm: assert property (p_rsm)
        else $error("wrong system management return code");

    property p_swint;
        take && exit_ok && i_exit_req.cause == VXE_SWINT |=> o_cb.code == 64'h75;
    endproperty
    a_swint: assert property (p_swint)
        else $error("wrong software interrupt code");

    property p_nmi;
        take && exit_ok && i_exit_req.cause == VXE_NMI |=> o_cb.code == 64'h61;
    endproperty
    a_nmi: assert property (p_nmi)
        else $error("wrong non-maskable interrupt code");

    property p_resume_after_store;
        $rose(state == VXE_ST_RESUME) |-> $past(stored) && !o_cb_wr_valid;
    endproperty
    a_resume_after_store: assert property (p_resume_after_store)
        else $error("host resumed before the code was stored");

    property p_one_store;
        stored && i_en |=> !o_cb_wr_valid && $stable(o_cb.code);
    endproperty
    a_one_store: assert property (p_one_store)
        else $error("more than one store for one exit");

    // -------------------------------------------------------------------------
    // Handshake and freeze assertions
    // -------------------------------------------------------------------------
    // A frozen block must not drift, or a pending store could change under the memory
    property p_freeze;
        !i_en
            |=> $stable(state) && $stable(o_cb) && $stable(o_no_exit) && $stable(o_cause_error);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while the clock enable was low");

    // Slow memory: the store group must stand still until it is accepted
    property p_store_hold;
        o_cb_wr_valid && !i_cb_wr_ready && i_en
            |=> state == VXE_ST_STORE && $stable(o_cb);
    endproperty
    a_store_hold: assert property (p_store_hold)
        else $error("store group changed before it was accepted");

    property p_resume_pulse;
        o_resume_host |=> state == VXE_ST_IDLE;
    endproperty
    a_resume_pulse: assert property (p_resume_pulse)
        else $error("resume lasted more than one enabled cycle");

    property p_bad_cause;
        take && !map_ok
            |=> o_cause_error && state == VXE_ST_IDLE && $stable(o_cb.code);
    endproperty
    a_bad_cause: assert property (p_bad_cause)
        else $error("invalid cause was not refused");

    property p_no_exit_keep;
        take && map_ok && !exit_ok
            |=> !o_cb_wr_valid && $stable(o_cb);
    endproperty
    a_no_exit_keep: assert property (p_no_exit_keep)
        else $error("store group touched without an exit");

    property p_detail_zero;
        take && exit_ok && !is_smi
            |=> !o_cb.detail_we && o_cb.detail == 64'h0;
    endproperty
    a_detail_zero: assert property (p_detail_zero)
        else $error("detail written for a cause that has none");

    property p_store_after_take;
        $rose(state == VXE_ST_STORE) |-> $past(take);
    endproperty
    a_store_after_take: assert property (p_store_after_take)
        else $error("store started without a taken exit");

    // Only one outcome may follow a taken request
    property p_one_outcome;
        o_no_exit |-> !o_cause_error && !o_cb_wr_valid;
    endproperty
    a_one_outcome: assert property (p_one_outcome)
        else $error("more than one outcome for one request");

endmodule : vxe_exit_encoder
`default_nettype wire

// [vxe_pkg.sv]
// Constants, exit causes and carrier structs for the guest exit code encoder.
// Assumes one core clock domain; every user of this package imports it whole.
package vxe_pkg;

    // -------------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------------
    localparam int VXE_FIELD_W = 64;
    localparam int VXE_CODE_W  = 8;
    localparam int VXE_VEC_W   = 142;

    // -------------------------------------------------------------------------
    // Exit codes
    // -------------------------------------------------------------------------
    localparam logic [7:0] VXE_CTL_RD_BASE = 8'h00;
    localparam logic [7:0] VXE_CTL_WR_BASE = 8'h10;
    localparam logic [7:0] VXE_DBG_RD_BASE = 8'h20;
    localparam logic [7:0] VXE_DBG_WR_BASE = 8'h30;
    localparam logic [7:0] VXE_EXCP_BASE   = 8'h40;
    localparam logic [7:0] VXE_CODE_INTR   = 8'h60;
    localparam logic [7:0] VXE_CODE_NMI    = 8'h61;
    localparam logic [7:0] VXE_CODE_SMI    = 8'h62;
    localparam logic [7:0] VXE_CODE_INIT   = 8'h63;
    localparam logic [7:0] VXE_CODE_VINTR  = 8'h64;
    localparam logic [7:0] VXE_CODE_SEL0   = 8'h65;
    localparam logic [7:0] VXE_CODE_IDTR   = 8'h66;
    localparam logic [7:0] VXE_CODE_GDTR   = 8'h67;
    localparam logic [7:0] VXE_CODE_LDTR   = 8'h68;
    localparam logic [7:0] VXE_CODE_TR     = 8'h69;
    localparam logic [7:0] VXE_CODE_PUSHF  = 8'h70;
    localparam logic [7:0] VXE_CODE_POPF   = 8'h71;
    localparam logic [7:0] VXE_CODE_RSM    = 8'h73;
    localparam logic [7:0] VXE_CODE_SWINT  = 8'h75;
    localparam logic [7:0] VXE_CODE_TOP    = 8'h8d;

    // -------------------------------------------------------------------------
    // Control register zero field positions (plain defaults)
    // -------------------------------------------------------------------------
    localparam int VXE_TS_BIT = 3;
    localparam int VXE_MP_BIT = 1;

    // -------------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------------
    typedef enum logic [4:0] {
        VXE_CTL_RD = 5'h00, VXE_CTL_WR = 5'h01, VXE_DBG_RD = 5'h02,
        VXE_DBG_WR = 5'h03, VXE_EXCP   = 5'h04, VXE_INTR   = 5'h05,
        VXE_NMI    = 5'h06, VXE_SMI    = 5'h07, VXE_INIT   = 5'h08,
        VXE_VINTR  = 5'h09, VXE_SEL0   = 5'h0a, VXE_IDTR   = 5'h0b,
        VXE_GDTR   = 5'h0c, VXE_LDTR   = 5'h0d, VXE_TR     = 5'h0e,
        VXE_PUSHF  = 5'h0f, VXE_POPF   = 5'h10, VXE_RSM    = 5'h11,
        VXE_SWINT  = 5'h12
    } vxe_cause_t;

    typedef enum logic [1:0] {
        VXE_ST_IDLE   = 2'b00,
        VXE_ST_STORE  = 2'b01,
        VXE_ST_RESUME = 2'b10
    } vxe_state_t;

    typedef struct packed {
        vxe_cause_t       cause;
        logic [4:0]       idx;
        logic [63:0]      detail;
        logic [63:0]      old_ctl0;
        logic [63:0]      new_ctl0;
    } vxe_exit_req_t;

    typedef struct packed {
        logic [63:0]      code;
        logic [63:0]      detail;
        logic             detail_we;
    } vxe_cb_wr_t;

endpackage : vxe_pkg

// [vxe_ctl0_filter.sv]
// Detects a control register zero write that changes more than the two ignored bits.
// Assumes old and new values are stable while the request is offered.
`timescale 1ns/10ps
`default_nettype none
module vxe_ctl0_filter
    import vxe_pkg::*;
#(
    parameter int TS_BIT = VXE_TS_BIT,
    parameter int MP_BIT = VXE_MP_BIT
)(
    input  wire logic [63:0] i_old,
    input  wire logic [63:0] i_new,
    output logic             o_other_change
);

    localparam logic [63:0] IGNORE_MASK = (64'h1 << TS_BIT) | (64'h1 << MP_BIT);

    assign o_other_change = |((i_old ^ i_new) & ~IGNORE_MASK);

endmodule : vxe_ctl0_filter
`default_nettype wire

// [vxe_code_map.sv]
// Maps an exit cause and its index to the eight-bit exit code.
// Purely combinational; an index beyond the cause's range reports not ok.
`timescale 1ns/10ps
`default_nettype none
module vxe_code_map
    import vxe_pkg::*;
(
    input  wire vxe_cause_t  i_cause,
    input  wire logic [4:0]  i_idx,
    output logic [7:0]       o_code,
    output logic             o_ok
);

    logic [7:0] reg_off;
    logic [7:0] vec_off;
    logic       reg_ok;

    assign reg_off = {4'h0, i_idx[3:0]};
    assign vec_off = {3'h0, i_idx};
    assign reg_ok  = ~i_idx[4];

    always_comb
    begin
        o_ok   = 1'b1;
        o_code = 8'h00;
        case (i_cause)
            VXE_CTL_RD: begin o_code = VXE_CTL_RD_BASE + reg_off; o_ok = reg_ok; end
            VXE_CTL_WR: begin o_code = VXE_CTL_WR_BASE + reg_off; o_ok = reg_ok; end
            VXE_DBG_RD: begin o_code = VXE_DBG_RD_BASE + reg_off; o_ok = reg_ok; end
            VXE_DBG_WR: begin o_code = VXE_DBG_WR_BASE + reg_off; o_ok = reg_ok; end
            VXE_EXCP:   o_code = VXE_EXCP_BASE + vec_off;
            VXE_INTR:   o_code = VXE_CODE_INTR;
            VXE_NMI:    o_code = VXE_CODE_NMI;
            VXE_SMI:    o_code = VXE_CODE_SMI;
            VXE_INIT:   o_code = VXE_CODE_INIT;
            VXE_VINTR:  o_code = VXE_CODE_VINTR;
            VXE_SEL0:   o_code = VXE_CODE_SEL0;
            VXE_IDTR:   o_code = VXE_CODE_IDTR;
            VXE_GDTR:   o_code = VXE_CODE_GDTR;
            VXE_LDTR:   o_code = VXE_CODE_LDTR;
            VXE_TR:     o_code = VXE_CODE_TR;
            VXE_PUSHF:  o_code = VXE_CODE_PUSHF;
            VXE_POPF:   o_code = VXE_CODE_POPF;
            VXE_RSM:    o_code = VXE_CODE_RSM;
            VXE_SWINT:  o_code = VXE_CODE_SWINT;
            default:    o_ok   = 1'b0;
        endcase
    end

endmodule : vxe_code_map
`default_nettype wire

// [vxe_host_mem_model.sv]
// Behavioural model of the memory side that takes control block stores.
// Assumes the encoder's store group is sampled on the rising edge of i_clk.
`timescale 1ns/10ps
`default_nettype none
module vxe_host_mem_model
    import vxe_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_valid,
    input  wire vxe_cb_wr_t i_cb,
    input  wire logic [3:0] i_stall,
    output logic            o_ready,
    output vxe_cb_wr_t      o_last,
    output int              o_count
);
    int wt;

    // -------------------------------------------------------------------------
    // Store acceptance
    // -------------------------------------------------------------------------
    // Ready only rises after i_stall waiting cycles, so slow memory is exercised
    always @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_ready = 1'b0;
            wt      = 0;
            o_count = 0;
            o_last  = '0;
        end
        else
        begin
            if (i_valid && o_ready)
            begin
                o_last  = i_cb;
                o_count = o_count + 1;
            end
            #1;
            if (!i_valid)
            begin
                o_ready = 1'b0;
                wt      = 0;
            end
            else
            begin
                o_ready = (wt >= i_stall);
                wt      = wt + 1;
            end
        end
    end
endmodule : vxe_host_mem_model
`default_nettype wire

// [vxe_exit_encoder_test.sv]
// Self-checking testbench for the guest exit code encoder.
// Assumes the memory model answers stores; all inputs move 1 ns after the edge.
`timescale 1ns/10ps
`default_nettype none
module vxe_exit_encoder_test
    import vxe_pkg::*;
;
    logic                 i_clk;
    logic                 i_rst_b;
    logic                 i_en;
    logic                 i_exit_valid;
    vxe_exit_req_t        i_exit_req;
    logic [VXE_VEC_W-1:0] i_intercept_vec;
    logic                 cb_ready;
    logic                 exit_ready;
    logic                 cb_valid;
    logic                 resume;
    logic                 no_exit;
    logic                 cause_err;
    logic [3:0]           stall;
    vxe_cb_wr_t           cb;
    vxe_cb_wr_t           last;
    int                   count;
    int                   err_count;
    int                   checks;

    vxe_exit_encoder #(.VEC_W(VXE_VEC_W)) vxe_exit_encoder_i (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_en(i_en), .i_exit_valid(i_exit_valid),
        .i_exit_req(i_exit_req), .i_intercept_vec(i_intercept_vec), .i_cb_wr_ready(cb_ready),
        .o_exit_ready(exit_ready), .o_cb_wr_valid(cb_valid), .o_cb(cb), .o_resume_host(resume),
        .o_no_exit(no_exit), .o_cause_error(cause_err));

    vxe_host_mem_model vxe_host_mem_model_i (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_valid(cb_valid), .i_cb(cb), .i_stall(stall),
        .o_ready(cb_ready), .o_last(last), .o_count(count));

    // -------------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------------
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // Kind 0 expects a store, 1 no exit, 2 a cause error; vec_on clears the code's bit when low
    task automatic run_one(input vxe_cause_t c, input logic [4:0] idx, input logic [63:0] oldv,
                           input logic [63:0] newv, input logic [63:0] det, input logic [7:0] code,
                           input logic [1:0] kind, input logic vec_on);
        int n0;
        int k;
        n0 = count;
        k  = 0;
        i_intercept_vec = {VXE_VEC_W{1'b1}};
        if (!vec_on)
            i_intercept_vec[code] = 1'b0;
        i_exit_req   = '{cause: c, idx: idx, detail: det, old_ctl0: oldv, new_ctl0: newv};
        i_exit_valid = 1'b1;
        while (exit_ready !== 1'b1 && k < 20)
        begin
            @(posedge i_clk) #1;
            k++;
        end
        @(posedge i_clk) #1;
        i_exit_valid = 1'b0;
        chk("cb_wr_valid", 64'(kind == 2'd0), 64'(cb_valid));
        chk("no_exit", 64'(kind == 2'd1), 64'(no_exit));
        chk("cause_error", 64'(kind == 2'd2), 64'(cause_err));
        if (kind == 2'd0)
        begin
            k = 0;
            while (resume !== 1'b1 && k < 20)
            begin
                @(posedge i_clk) #1;
                k++;
            end
            chk("resume_host", 64'h1, 64'(resume));
            chk("store_count", 64'(n0 + 1), 64'(count));
            chk("exit_code", {56'h0, code}, last.code);
            chk("detail_we", 64'(c == VXE_SMI), 64'(last.detail_we));
            if (c == VXE_SMI)
                chk("detail", det, last.detail);
        end
        else
            chk("store_count", 64'(n0), 64'(count));
        @(posedge i_clk) #1;
    endtask : run_one

    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic t_regs();
        for (int n = 0; n < 16; n++)
        begin
            stall = 4'(n % 4);
            run_one(VXE_CTL_RD, 5'(n), 0, 0, 0, 8'h00 + 8'(n), 0, 1);
            run_one(VXE_CTL_WR, 5'(n), 0, 0, 0, 8'h10 + 8'(n), 0, 1);
            run_one(VXE_DBG_RD, 5'(n), 0, 0, 0, 8'h20 + 8'(n), 0, 1);
            run_one(VXE_DBG_WR, 5'(n), 0, 0, 0, 8'h30 + 8'(n), 0, 1);
        end
        $display("test regs done");
    endtask : t_regs

    task automatic t_excp();
        for (int v = 0; v < 32; v++)
            run_one(VXE_EXCP, 5'(v), 0, 0, 0, 8'h40 + 8'(v), 0, 1);
        $display("test excp done");
    endtask : t_excp

    task automatic t_fixed();
        vxe_cause_t cs[12];
        logic [7:0] cd[12];
        cs = '{VXE_INTR, VXE_NMI, VXE_INIT, VXE_VINTR, VXE_IDTR, VXE_GDTR,
               VXE_LDTR, VXE_TR, VXE_PUSHF, VXE_POPF, VXE_RSM, VXE_SWINT};
        cd = '{8'h60, 8'h61, 8'h63, 8'h64, 8'h66, 8'h67, 8'h68, 8'h69, 8'h70, 8'h71, 8'h73, 8'h75};
        stall = 4'h2;
        run_one(VXE_SMI, 0, 0, 0, 64'h0123_4567_89ab_cdef, 8'h62, 0, 1);
        for (int i = 0; i < 12; i++)
            run_one(cs[i], 0, 0, 0, 64'hffff_0000_ffff_0000, cd[i], 0, 1);
        $display("test fixed done");
    endtask : t_fixed

    task automatic t_sel();
        stall = 4'h0;
        run_one(VXE_SEL0, 0, 64'h0, 64'h0a, 0, 8'h65, 1, 1);
        run_one(VXE_SEL0, 0, 64'h0a, 64'h0b, 0, 8'h65, 0, 1);
        run_one(VXE_SEL0, 0, 64'h0, 64'h8000_0000_0000_0000, 0, 8'h65, 0, 1);
        $display("test sel done");
    endtask : t_sel

    task automatic t_gate();
        run_one(VXE_CTL_WR, 5'h05, 0, 0, 0, 8'h15, 1, 0);
        run_one(VXE_NMI, 0, 0, 0, 0, 8'h61, 1, 0);
        run_one(VXE_DBG_RD, 5'h10, 0, 0, 0, 8'h00, 2, 1);
        run_one(VXE_EXCP, 5'h1f, 0, 0, 0, 8'h5f, 0, 1);
        $display("test gate done");
    endtask : t_gate

    // Clock enable drops while the store is pending; nothing may move until it returns
    task automatic t_freeze();
        int n0;
        int k;
        n0 = count;
        k  = 0;
        stall           = 4'h0;
        i_intercept_vec = {VXE_VEC_W{1'b1}};
        i_exit_req      = '{cause: VXE_INTR, idx: 5'h0, detail: 64'h0, old_ctl0: 64'h0, new_ctl0: 64'h0};
        i_exit_valid    = 1'b1;
        @(posedge i_clk) #1;
        i_exit_valid = 1'b0;
        i_en         = 1'b0;
        repeat (3) @(posedge i_clk) #1;
        chk("frozen_valid", 64'h0, 64'(cb_valid));
        chk("frozen_code", 64'h60, cb.code);
        chk("frozen_count", 64'(n0), 64'(count));
        i_en = 1'b1;
        while (resume !== 1'b1 && k < 20)
        begin
            @(posedge i_clk) #1;
            k++;
        end
        chk("thawed_resume", 64'h1, 64'(resume));
        chk("thawed_count", 64'(n0 + 1), 64'(count));
        chk("thawed_code", 64'h60, last.code);
        @(posedge i_clk) #1;
        $display("test freeze done");
    endtask : t_freeze

    // -------------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // -------------------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    initial
    begin
        #200000;
        err_count++;
        conclude();
    end

    initial
    begin
        err_count       = 0;
        checks          = 0;
        i_rst_b         = 1'b0;
        i_en            = 1'b1;
        i_exit_valid    = 1'b0;
        i_exit_req      = '0;
        i_intercept_vec = '0;
        stall           = 4'h0;
        repeat (12) @(posedge i_clk);
        #1;
        i_rst_b = 1'b1;
        chk("reset_code", 64'h0, cb.code);
        chk("reset_ready", 64'h1, 64'(exit_ready));
        chk("reset_resume", 64'h0, 64'(resume));
        t_regs();
        t_excp();
        t_fixed();
        t_sel();
        t_gate();
        t_freeze();
        conclude();
    end
endmodule : vxe_exit_encoder_test
`default_nettype wire
